// ===== rtl/ivw_core.sv
// Decided for this implementation: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
module ivw_core import ivw_pkg::*; (
   // Clock and reset.
   input  wire logic                            clk,
   input  wire logic                            reset_n,
   // Wishbone slave.
   input  wire logic                            wb_cyc_i,
   input  wire logic                            wb_stb_i,
   input  wire logic                            wb_we_i,
   input  wire logic [7:0]                      wb_adr_i,
   input  wire logic [3:0]                      wb_sel_i,
   input  wire logic [31:0]                     wb_dat_i,
   output logic      [31:0]                     wb_dat_o,
   output logic                                 wb_ack_o,
   // Reset and wake sources.
   input  wire logic [NUM_THREADS-1:0]          sysRstReq,
   input  wire ivw_wake_src_t                   wakeSrc,
   // Exception requests and pipeline handshake.
   input  wire ivw_exc_req_t [NUM_THREADS-1:0]  excReq,
   output logic      [NUM_THREADS-1:0]          excAck,
   output logic      [NUM_THREADS-1:0]          drainReq,
   input  wire logic [NUM_THREADS-1:0]          pipeDrained,
   // Taken interrupts and thread state.
   output ivw_take_t [NUM_THREADS-1:0]          takeOut,
   output logic      [NUM_THREADS-1:0]          threadEnable,
   output logic      [2*NUM_THREADS-1:0]        threadPrio
);

   // Expands byte selects into a bit mask for a masked register write.
   function automatic logic [31:0] laneMask(input logic [3:0] sel);
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < 4; i++) begin
         m[8*i +: 8] = {8{sel[i]}};
      end
      return m;
   endfunction

   // Applies a masked write to an old register word.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] sel);
      return (old & ~laneMask(sel)) | (wd & laneMask(sel));
   endfunction

   logic [31:0]                  cfg0_r;
   logic [31:0]                  cfg1_r;
   logic [31:0]                  tsw_r;
   logic [31:0]                  vecLo_r;
   logic [31:0]                  vecHi_r;
   logic [NUM_THREADS-1:0]       en_r;
   logic [2*NUM_THREADS-1:0]     prio_r;
   logic [3*NUM_THREADS-1:0]     reason_r;
   logic [NUM_THREADS-1:0]       ctlPend_r;
   logic                         ack_r;
   logic [31:0]                  dat_r;
   logic                         busReq;
   logic                         wrStb;
   logic                         ctlWrite;
   logic [31:0]                  ctlWord;
   logic [NUM_THREADS-1:0]       ctlWakeSet;
   logic [NUM_THREADS-1:0]       takeReset;
   logic [CFG_VEC_W-1:0]         cfgVec;
   ivw_take_t [NUM_THREADS-1:0]  take_r;

   // A request is served once; ack drops in the cycle after it is given.
   assign busReq   = wb_cyc_i && wb_stb_i && !ack_r;
   assign wrStb    = busReq && wb_we_i;
   assign ctlWrite = wrStb && (wb_adr_i == REG_THCTL);
   assign ctlWord  = merge({24'h00, prio_r, 2'h0, en_r}, wb_dat_i, wb_sel_i);
   assign cfgVec   = {vecHi_r[VEC_HI_W-1:0], vecLo_r};
   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;
   assign takeOut  = take_r;
   assign threadEnable = en_r;
   assign threadPrio   = prio_r;

   // Bus answer: every access is acked one cycle later, unmapped reads give zero.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ack_r <= 1'b0;
         dat_r <= 32'h0000_0000;
      end else begin
         ack_r <= busReq;
         if (busReq && !wb_we_i) begin
            case (wb_adr_i)
               REG_CFG0:   dat_r <= cfg0_r;
               REG_CFG1:   dat_r <= cfg1_r;
               REG_TSW:    dat_r <= tsw_r;
               REG_THCTL:  dat_r <= {24'h00, prio_r, 2'h0, en_r};
               REG_VEC_LO: dat_r <= vecLo_r;
               REG_VEC_HI: dat_r <= vecHi_r;
               REG_REASON: dat_r <= {25'h0, reason_r[5:3], 1'b0, reason_r[2:0]};
               default:    dat_r <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Configuration words; only the implemented bits are kept so the rest read zero.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cfg0_r  <= 32'h0000_0000;
         cfg1_r  <= 32'h0000_0000;
         tsw_r   <= 32'h0000_0000;
         vecLo_r <= 32'h0000_0000;
         vecHi_r <= 32'h0000_0000;
      end else if (wrStb) begin
         case (wb_adr_i)
            REG_CFG0:   cfg0_r  <= merge(cfg0_r, wb_dat_i, wb_sel_i) & 32'h0000_0003;
            REG_CFG1:   cfg1_r  <= merge(cfg1_r, wb_dat_i, wb_sel_i) & 32'h0000_0001;
            REG_TSW:    tsw_r   <= merge(tsw_r, wb_dat_i, wb_sel_i) & 32'h0000_0007;
            REG_VEC_LO: vecLo_r <= merge(vecLo_r, wb_dat_i, wb_sel_i);
            REG_VEC_HI: vecHi_r <= merge(vecHi_r, wb_dat_i, wb_sel_i) & 32'h0000_00ff;
            default:    cfg0_r  <= cfg0_r;
         endcase
      end
   end

   // A control write that turns on a stopped thread wakes it through a reset.
   always_comb begin
      for (int t = 0; t < NUM_THREADS; t++) begin
         ctlWakeSet[t] = ctlWrite && ctlWord[CTL_EN_LSB + t] && !en_r[t];
         takeReset[t]  = take_r[t].take && take_r[t].isReset;
      end
   end

   // Thread enable and priority; the hardware set on a resume wins over software.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         en_r   <= '0;
         prio_r <= {NUM_THREADS{PRIO_RESET}};
      end else begin
         for (int t = 0; t < NUM_THREADS; t++) begin
            if (takeReset[t]) begin
               en_r[t]                 <= 1'b1;
               prio_r[PRIO_W*t +: PRIO_W] <= PRIO_HIGH;
            end else if (ctlWrite) begin
               en_r[t]                 <= ctlWord[CTL_EN_LSB + t];
               prio_r[PRIO_W*t +: PRIO_W] <= ctlWord[CTL_PRIO_LSB + PRIO_W*t +: PRIO_W];
            end
         end
      end
   end

   // Pending control wakes and reason codes; a new wake write beats the clear.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ctlPend_r <= '0;
         reason_r  <= '0;
      end else begin
         for (int t = 0; t < NUM_THREADS; t++) begin
            if (ctlWakeSet[t]) begin
               ctlPend_r[t] <= 1'b1;
            end else if (takeReset[t] && take_r[t].reason == RSN_POR) begin
               ctlPend_r[t] <= 1'b0;
            end
            if (takeReset[t]) begin
               reason_r[3*t +: 3] <= take_r[t].reason;
            end
         end
      end
   end

   // One sequencer per thread: select, drain the pipeline, then take.
   for (genvar t = 0; t < NUM_THREADS; t++) begin : g_thr
      ivw_state_t  state_r;
      logic        wake;
      logic [2:0]  wakeReason;
      logic        rstLat_r;
      logic [2:0]  rsnLat_r;
      ivw_exc_t    kindLat_r;
      logic [63:0] vector;

      ivw_wake_arb u_arb (
         .suspended (!en_r[t]),
         .rstReq    (sysRstReq[t]),
         .ctlWake   (ctlPend_r[t]),
         .therm     (wakeSrc.therm && cfg0_r[CFG0_THERM_BIT]),
         .sysErr    (wakeSrc.sysErr && cfg0_r[CFG0_SERR_BIT]),
         .ext       (wakeSrc.ext && tsw_r[TSW_EXT_BIT]),
         .dec       (wakeSrc.dec[t] && tsw_r[TSW_DEC_LSB + t]),
         .wake      (wake),
         .reason    (wakeReason)
      );

      ivw_vector_map u_map (
         .kind        (kindLat_r),
         .isReset     (rstLat_r),
         .threadOne   (t != 0),
         .vecOverride (cfg1_r[CFG1_OVR_BIT]),
         .cfgVec      (cfgVec),
         .vector      (vector)
      );

      // Resets outrank ordinary exceptions while the sequencer is idle.
      assign excAck[t]   = (state_r == ST_IDLE) && !wake && excReq[t].valid;
      assign drainReq[t] = (state_r == ST_DRAIN);

      // State register and latched selection.
      always_ff @(posedge clk) begin
         if (!reset_n) begin
            state_r   <= ST_IDLE;
            rstLat_r  <= 1'b0;
            rsnLat_r  <= RSN_NONE;
            kindLat_r <= EXC_MCHK;
         end else begin
            case (state_r)
               ST_IDLE: begin
                  if (wake || excReq[t].valid) begin
                     state_r   <= ST_DRAIN;
                     rstLat_r  <= wake;
                     rsnLat_r  <= wakeReason;
                     kindLat_r <= excReq[t].kind;
                  end
               end
               ST_DRAIN: begin
                  if (pipeDrained[t]) begin
                     state_r <= ST_TAKE;
                  end
               end
               ST_TAKE: state_r <= ST_IDLE;
               default: state_r <= ST_IDLE;
            endcase
         end
      end

      // The vector is resolved at the drain edge so configuration is current.
      always_ff @(posedge clk) begin
         if (!reset_n) begin
            take_r[t] <= '0;
         end else if (state_r == ST_DRAIN && pipeDrained[t]) begin
            take_r[t].take    <= 1'b1;
            take_r[t].isReset <= rstLat_r;
            take_r[t].setHv   <= rstLat_r;
            take_r[t].setSf   <= rstLat_r;
            take_r[t].reason  <= rstLat_r ? rsnLat_r : RSN_NONE;
            take_r[t].vector  <= vector;
         end else begin
            take_r[t].take <= 1'b0;
         end
      end

      property p_vec_a;
         @(posedge clk) disable iff (!reset_n) take_r[t].take && !take_r[t].isReset |->
            (kindLat_r != EXC_MCHK || take_r[t].vector == VEC_MCHK) &&
            (kindLat_r != EXC_DSTOR || take_r[t].vector == VEC_DSTOR) &&
            (kindLat_r != EXC_DSEG || take_r[t].vector == VEC_DSEG);
      endproperty
      a_vec_a: assert property (p_vec_a) else $error("bad vector group a");

      property p_vec_b;
         @(posedge clk) disable iff (!reset_n) take_r[t].take && !take_r[t].isReset |->
            (kindLat_r != EXC_ISTOR || take_r[t].vector == VEC_ISTOR) &&
            (kindLat_r != EXC_EXT || take_r[t].vector == VEC_EXT);
      endproperty
      a_vec_b: assert property (p_vec_b) else $error("bad vector group b");

      property p_vec_c;
         @(posedge clk) disable iff (!reset_n) take_r[t].take && !take_r[t].isReset |->
            (kindLat_r != EXC_HDEC || take_r[t].vector == VEC_HDEC) &&
            (kindLat_r != EXC_THERM || take_r[t].vector == VEC_THERM);
      endproperty
      a_vec_c: assert property (p_vec_c) else $error("bad vector group c");

      property p_vec_d;
         @(posedge clk) disable iff (!reset_n) take_r[t].take && !take_r[t].isReset |->
            (kindLat_r != EXC_ALIGN || take_r[t].vector == VEC_ALIGN) &&
            (kindLat_r != EXC_VUNAV || take_r[t].vector == VEC_VUNAV) &&
            (kindLat_r != EXC_SYSERR || take_r[t].vector == VEC_SYSERR);
      endproperty
      a_vec_d: assert property (p_vec_d) else $error("bad vector group d");

      property p_no_perf;
         @(posedge clk) disable iff (!reset_n) take_r[t].take |->
            take_r[t].vector != VEC_PERFMON;
      endproperty
      a_no_perf: assert property (p_no_perf) else $error("perf vector taken");

      property p_hv_sf;
         @(posedge clk) disable iff (!reset_n) take_r[t].take |->
            take_r[t].setHv == take_r[t].isReset && take_r[t].setSf == take_r[t].isReset;
      endproperty
      a_hv_sf: assert property (p_hv_sf) else $error("hv or sf wrong");

      property p_rst_vec;
         @(posedge clk) disable iff (!reset_n) takeReset[t] &&
            (t != 0 || $past(cfg1_r[CFG1_OVR_BIT])) |-> take_r[t].vector == VEC_SRST_FIX;
      endproperty
      a_rst_vec: assert property (p_rst_vec) else $error("fixed reset vector wrong");

      property p_cfg_vec;
         @(posedge clk) disable iff (!reset_n) takeReset[t] && t == 0 &&
            !$past(cfg1_r[CFG1_OVR_BIT]) |->
            take_r[t].vector == {22'h000000, $past(cfgVec), 2'h0};
      endproperty
      a_cfg_vec: assert property (p_cfg_vec) else $error("config reset vector wrong");

      property p_drained;
         @(posedge clk) disable iff (!reset_n) $rose(take_r[t].take) |->
            $past(drainReq[t]) && $past(pipeDrained[t]);
      endproperty
      a_drained: assert property (p_drained) else $error("taken before drain");

      property p_resume;
         @(posedge clk) disable iff (!reset_n) takeReset[t] |=>
            en_r[t] && prio_r[PRIO_W*t +: PRIO_W] == PRIO_HIGH && take_r[t].take == 1'b0;
      endproperty
      a_resume: assert property (p_resume) else $error("resume state wrong");

      // A thermal, system error or external wake reason is only accepted while its own enable is on.
      property p_wake_en;
         @(posedge clk) disable iff (!reset_n) state_r == ST_IDLE && wake |->
            (wakeReason != RSN_EXT || tsw_r[TSW_EXT_BIT]) &&
            (wakeReason != RSN_THERM || cfg0_r[CFG0_THERM_BIT]) &&
            (wakeReason != RSN_SYSERR || cfg0_r[CFG0_SERR_BIT]);
      endproperty
      a_wake_en: assert property (p_wake_en) else $error("ungated wake");

      property p_reason;
         @(posedge clk) disable iff (!reset_n) takeReset[t] |=>
            reason_r[3*t +: 3] == $past(take_r[t].reason);
      endproperty
      a_reason: assert property (p_reason) else $error("reason code not kept");

      c_normal: cover property (@(posedge clk) take_r[t].take && !take_r[t].isReset);
      c_reset:  cover property (@(posedge clk) takeReset[t] && take_r[t].reason == RSN_POR);
      c_wake:   cover property (@(posedge clk) takeReset[t] && take_r[t].reason == RSN_DEC);
      c_ext:    cover property (@(posedge clk) takeReset[t] && take_r[t].reason == RSN_EXT);
   end

endmodule

// ===== rtl/ivw_pkg.sv
package ivw_pkg;

   // Core geometry.
   localparam int NUM_THREADS = 2;
   localparam int CFG_VEC_W   = 40;
   localparam int CFG_VEC_LSB = 2;
   localparam int PRIO_W      = 2;

   // Interrupt kinds that the core can raise besides system reset.
   typedef enum logic [4:0] {
      EXC_MCHK   = 5'h00, EXC_DSTOR  = 5'h01, EXC_DSEG   = 5'h02, EXC_ISTOR  = 5'h03,
      EXC_ISEG   = 5'h04, EXC_EXT    = 5'h05, EXC_ALIGN  = 5'h06, EXC_PROG   = 5'h07,
      EXC_FPUNAV = 5'h08, EXC_DEC    = 5'h09, EXC_HDEC   = 5'h0a, EXC_SYSCAL = 5'h0b,
      EXC_TRACE  = 5'h0c, EXC_VUNAV  = 5'h0d, EXC_SYSERR = 5'h0e, EXC_MAINT  = 5'h0f,
      EXC_THERM  = 5'h10
   } ivw_exc_t;

   // Fixed vector addresses.
   localparam logic [63:0] VEC_MCHK     = 64'h0000_0000_0000_0200;
   localparam logic [63:0] VEC_DSTOR    = 64'h0000_0000_0000_0300;
   localparam logic [63:0] VEC_DSEG     = 64'h0000_0000_0000_0380;
   localparam logic [63:0] VEC_ISTOR    = 64'h0000_0000_0000_0400;
   localparam logic [63:0] VEC_ISEG     = 64'h0000_0000_0000_0480;
   localparam logic [63:0] VEC_EXT      = 64'h0000_0000_0000_0500;
   localparam logic [63:0] VEC_ALIGN    = 64'h0000_0000_0000_0600;
   localparam logic [63:0] VEC_PROG     = 64'h0000_0000_0000_0700;
   localparam logic [63:0] VEC_FPUNAV   = 64'h0000_0000_0000_0800;
   localparam logic [63:0] VEC_DEC      = 64'h0000_0000_0000_0900;
   localparam logic [63:0] VEC_HDEC     = 64'h0000_0000_0000_0980;
   localparam logic [63:0] VEC_SYSCAL   = 64'h0000_0000_0000_0c00;
   localparam logic [63:0] VEC_TRACE    = 64'h0000_0000_0000_0d00;
   localparam logic [63:0] VEC_PERFMON  = 64'h0000_0000_0000_0f00;
   localparam logic [63:0] VEC_VUNAV    = 64'h0000_0000_0000_0f20;
   localparam logic [63:0] VEC_SYSERR   = 64'h0000_0000_0000_1200;
   localparam logic [63:0] VEC_MAINT    = 64'h0000_0000_0000_1600;
   localparam logic [63:0] VEC_THERM    = 64'h0000_0000_0000_1800;
   localparam logic [63:0] VEC_SRST_FIX = 64'h0000_0000_0000_0100;

   // Reset reason codes.
   localparam logic [2:0] RSN_NONE   = 3'h0;
   localparam logic [2:0] RSN_THERM  = 3'h2;
   localparam logic [2:0] RSN_DEC    = 3'h3;
   localparam logic [2:0] RSN_EXT    = 3'h4;
   localparam logic [2:0] RSN_POR    = 3'h5;
   localparam logic [2:0] RSN_SYSERR = 3'h6;

   // Register byte offsets and field positions.
   localparam logic [7:0] REG_CFG0    = 8'h00;
   localparam logic [7:0] REG_CFG1    = 8'h04;
   localparam logic [7:0] REG_TSW     = 8'h08;
   localparam logic [7:0] REG_THCTL   = 8'h0c;
   localparam logic [7:0] REG_VEC_LO  = 8'h10;
   localparam logic [7:0] REG_VEC_HI  = 8'h14;
   localparam logic [7:0] REG_REASON  = 8'h18;
   localparam int CFG0_THERM_BIT = 0;
   localparam int CFG0_SERR_BIT  = 1;
   localparam int CFG1_OVR_BIT   = 0;
   localparam int TSW_EXT_BIT    = 0;
   localparam int TSW_DEC_LSB    = 1;
   localparam int CTL_EN_LSB     = 0;
   localparam int CTL_PRIO_LSB   = 4;
   localparam int RSN_STRIDE     = 4;
   localparam int VEC_HI_W       = CFG_VEC_W - 32;
   localparam logic [PRIO_W-1:0] PRIO_HIGH  = 2'h3;
   localparam logic [PRIO_W-1:0] PRIO_RESET = 2'h2;

   // Per-thread sequencer states.
   typedef enum logic [2:0] {ST_IDLE = 3'h1, ST_DRAIN = 3'h2, ST_TAKE = 3'h4} ivw_state_t;

   // Request from the exception logic of one thread.
   typedef struct packed {
      logic     valid;
      ivw_exc_t kind;
   } ivw_exc_req_t;

   // Wake sources shared by the threads, decrementer per thread.
   typedef struct packed {
      logic                   therm;
      logic                   sysErr;
      logic                   ext;
      logic [NUM_THREADS-1:0] dec;
   } ivw_wake_src_t;

   // Interrupt taken by one thread.
   typedef struct packed {
      logic        take;
      logic        isReset;
      logic        setHv;
      logic        setSf;
      logic [2:0]  reason;
      logic [63:0] vector;
   } ivw_take_t;

endpackage

// ===== rtl/ivw_vector_map.sv
`timescale 1ns/1ps
module ivw_vector_map import ivw_pkg::*; (
   // Selection.
   input  wire ivw_exc_t           kind,
   input  wire logic               isReset,
   input  wire logic               threadOne,
   // Reset vector configuration.
   input  wire logic               vecOverride,
   input  wire logic [CFG_VEC_W-1:0] cfgVec,
   // Result.
   output logic [63:0]             vector
);

   // Fixed table; the unimplemented performance monitor slot is never produced.
   always_comb begin
      vector = VEC_MCHK;
      if (isReset) begin
         if (threadOne || vecOverride) begin
            vector = VEC_SRST_FIX;
         end else begin
            vector = '0;
            vector[CFG_VEC_LSB +: CFG_VEC_W] = cfgVec;
         end
      end else begin
         case (kind)
            EXC_MCHK:   vector = VEC_MCHK;
            EXC_DSTOR:  vector = VEC_DSTOR;
            EXC_DSEG:   vector = VEC_DSEG;
            EXC_ISTOR:  vector = VEC_ISTOR;
            EXC_ISEG:   vector = VEC_ISEG;
            EXC_EXT:    vector = VEC_EXT;
            EXC_ALIGN:  vector = VEC_ALIGN;
            EXC_PROG:   vector = VEC_PROG;
            EXC_FPUNAV: vector = VEC_FPUNAV;
            EXC_DEC:    vector = VEC_DEC;
            EXC_HDEC:   vector = VEC_HDEC;
            EXC_SYSCAL: vector = VEC_SYSCAL;
            EXC_TRACE:  vector = VEC_TRACE;
            EXC_VUNAV:  vector = VEC_VUNAV;
            EXC_SYSERR: vector = VEC_SYSERR;
            EXC_MAINT:  vector = VEC_MAINT;
            EXC_THERM:  vector = VEC_THERM;
            default:    vector = VEC_MCHK;
         endcase
      end
   end

endmodule

// ===== rtl/ivw_wake_arb.sv
`timescale 1ns/1ps
module ivw_wake_arb import ivw_pkg::*; (
   // Thread condition.
   input  wire logic       suspended,
   input  wire logic       rstReq,
   input  wire logic       ctlWake,
   // Wake sources, already gated by their enables.
   input  wire logic       therm,
   input  wire logic       sysErr,
   input  wire logic       ext,
   input  wire logic       dec,
   // Result.
   output logic            wake,
   output logic [2:0]      reason
);

   // Fixed priority so that a single reason is recorded per reset.
   always_comb begin
      wake   = 1'b1;
      reason = RSN_NONE;
      if (rstReq || ctlWake) begin
         reason = RSN_POR;
      end else if (suspended && sysErr) begin
         reason = RSN_SYSERR;
      end else if (suspended && therm) begin
         reason = RSN_THERM;
      end else if (suspended && ext) begin
         reason = RSN_EXT;
      end else if (suspended && dec) begin
         reason = RSN_DEC;
      end else begin
         wake = 1'b0;
      end
   end

endmodule

// ===== test/ivw_pipe_model.sv
`timescale 1ns/1ps
module ivw_pipe_model import ivw_pkg::*; (
   // Clock and reset.
   input  wire logic                   clk,
   input  wire logic                   reset_n,
   // Drain handshake.
   input  wire logic [NUM_THREADS-1:0] drainReq,
   input  wire logic                   slow,
   output logic      [NUM_THREADS-1:0] pipeDrained
);
   logic [1:0] waitCnt_r [NUM_THREADS];

   // Older work retires over a few cycles when slow, so a take must not come early.
   always_ff @(posedge clk) begin
      for (int t = 0; t < NUM_THREADS; t++) begin
         if (!reset_n || !drainReq[t]) begin
            waitCnt_r[t] <= 2'h0;
         end else if (waitCnt_r[t] != 2'h3) begin
            waitCnt_r[t] <= waitCnt_r[t] + 2'h1;
         end
      end
   end

   // Quiet is reported only while a drain is asked for.
   always_comb begin
      for (int t = 0; t < NUM_THREADS; t++) begin
         pipeDrained[t] = drainReq[t] && (!slow || waitCnt_r[t] == 2'h3);
      end
   end
endmodule

// ===== test/tb_top.sv
`timescale 1ns/1ps
module tb_top import ivw_pkg::*;;
   logic clk = 1'b0, resetN = 1'b0, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, slow = 1'b0;
   logic [7:0]  wbAdr = 8'h00;
   logic [31:0] wbDat = 32'h0, wbDatO, rdData;
   logic        wbAck;
   logic [1:0]  sysRstReq = 2'h0, excAck, drainReq, pipeDrained, threadEnable;
   logic [3:0]  threadPrio;
   ivw_wake_src_t                  wakeSrc = '0;
   ivw_exc_req_t [NUM_THREADS-1:0] excReq = '0;
   ivw_take_t    [NUM_THREADS-1:0] takeOut;
   ivw_take_t   lastTake [2];
   int          nTake [2] = '{0, 0};
   int          miscompares = 0, checks = 0, cycles = 0, n;
   ivw_exc_t    kinds [17] = '{EXC_MCHK, EXC_DSTOR, EXC_DSEG, EXC_ISTOR, EXC_ISEG, EXC_EXT,
      EXC_ALIGN, EXC_PROG, EXC_FPUNAV, EXC_DEC, EXC_HDEC, EXC_SYSCAL, EXC_TRACE, EXC_VUNAV,
      EXC_SYSERR, EXC_MAINT, EXC_THERM};
   logic [15:0] vecs [17] = '{16'h0200, 16'h0300, 16'h0380, 16'h0400, 16'h0480, 16'h0500,
      16'h0600, 16'h0700, 16'h0800, 16'h0900, 16'h0980, 16'h0c00, 16'h0d00, 16'h0f20,
      16'h1200, 16'h1600, 16'h1800};
   // Each row: thermal/error enables, switch enables, expected reason code.
   logic [11:0] wRow [4] = '{12'h043, 12'h054, 12'h152, 12'h356};

   ivw_core ivw_core_i (.clk(clk), .reset_n(resetN), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
      .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hf), .wb_dat_i(wbDat), .wb_dat_o(wbDatO),
      .wb_ack_o(wbAck), .sysRstReq(sysRstReq), .wakeSrc(wakeSrc), .excReq(excReq),
      .excAck(excAck), .drainReq(drainReq), .pipeDrained(pipeDrained), .takeOut(takeOut),
      .threadEnable(threadEnable), .threadPrio(threadPrio));
   ivw_pipe_model ivw_pipe_model_i (.clk(clk), .reset_n(resetN), .drainReq(drainReq),
      .slow(slow), .pipeDrained(pipeDrained));

   // Clock at 250 MHz.
   always #2 clk = ~clk;

   // Takes are latched and counted so a pulse cannot slip by during a bus cycle.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      for (int t = 0; t < 2; t++) begin
         if (takeOut[t].take === 1'b1) begin
            lastTake[t] <= takeOut[t];
            nTake[t]    <= nTake[t] + 1;
         end
      end
      if (cycles > 20000) begin
         miscompares++;
         stop_test();
      end
   end

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      if (miscompares == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Classic cycle held until ack is seen; the cycle timeout ends a hang.
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
      @(posedge clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe  <= we;
      wbAdr <= adr;
      wbDat <= d;
      do @(posedge clk); while (wbAck !== 1'b1);
      rdData = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask

   task automatic waitTake(input int t, input int cnt);
      while (nTake[t] < cnt) @(posedge clk);
      chk(64'(nTake[t]), 64'(cnt));
   endtask

   task automatic pulseRst(input logic [1:0] m);
      @(posedge clk);
      sysRstReq <= m;
      @(posedge clk);
      sysRstReq <= 2'h0;
   endtask

   task automatic exc(input int t, input ivw_exc_t k);
      int c;
      c = nTake[t];
      @(posedge clk);
      excReq[t] <= {1'b1, k};
      do @(posedge clk); while (excAck[t] !== 1'b1);
      excReq[t] <= '0;
      waitTake(t, c + 1);
   endtask

   initial begin
      repeat (5) @(posedge clk);
      resetN <= 1'b1;
      wb(1'b1, REG_VEC_LO, 32'h89abcdef);
      wb(1'b1, REG_VEC_HI, 32'h45);
      wb(1'b0, REG_VEC_HI, 32'h0);
      chk(rdData, 32'h45);
      pulseRst(2'h3);
      waitTake(0, 1);
      waitTake(1, 1);
      chk(lastTake[0].vector, {22'h0, 40'h4589abcdef, 2'h0});
      chk(lastTake[1].vector, 64'h100);
      chk({lastTake[0].isReset, lastTake[0].setHv, lastTake[0].setSf}, 3'h7);
      @(negedge clk);
      chk(threadPrio, 4'hf);
      wb(1'b0, REG_REASON, 32'h0);
      chk(rdData, 32'h55);
      // Every exception kind's vector, the drain answered promptly and slowly in turn.
      for (int i = 0; i < 17; i++) begin
         slow <= i[0];
         exc(0, kinds[i]);
         chk(lastTake[0].vector, {48'h0, vecs[i]});
      end
      wb(1'b1, REG_CFG1, 32'h1);
      pulseRst(2'h1);
      waitTake(0, nTake[0] + 1);
      chk(lastTake[0].vector, 64'h100);
      // All sources stay high; only the enables decide whether and why a wake occurs.
      wakeSrc <= '1;
      for (int i = 0; i < 4; i++) begin
         wb(1'b1, REG_CFG0, 32'h0);
         wb(1'b1, REG_TSW, 32'h0);
         wb(1'b1, REG_THCTL, 32'h1);
         n = nTake[1];
         repeat (10) @(posedge clk);
         chk(64'(nTake[1]), 64'(n));
         wb(1'b1, REG_CFG0, {28'h0, wRow[i][11:8]});
         wb(1'b1, REG_TSW, {28'h0, wRow[i][7:4]});
         waitTake(1, n + 1);
         chk(lastTake[1].reason, wRow[i][2:0]);
         chk(threadEnable[1], 1'b1);
      end
      // Reset again in mid-run, then restart one thread.
      resetN <= 1'b0;
      @(posedge clk);
      resetN <= 1'b1;
      pulseRst(2'h2);
      waitTake(1, nTake[1] + 1);
      chk(lastTake[1].reason, 3'h5);
      stop_test();
   end
endmodule
